// File: hdl/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
`include "dac_ctrl_regs.svh"

	typedef logic [`DATA_BITS-1:0] code_type;
	typedef code_type [`NUM_CH-1:0] bank_type;
	typedef logic [`FIFO_WIDTH-1:0] entry_type;

	typedef enum logic {
		LINK_IDLE,
		LINK_SHIFT
	} link_type;

	typedef struct packed {
		logic [`PIN_W-1:0] meta;
		logic [`PIN_W-1:0] pins;
		logic sclk_prev;
		logic load_prev;
		link_type link;
		logic [`CNT_W-1:0] count;
		logic [`WORD_BITS-1:0] shift;
		logic out_bit;
		logic push;
		entry_type push_word;
		logic dropped;
		bank_type input_code;
		bank_type dac_code;
	} state_type;
endpackage

// File: hdl/dac_ctrl_regs.svh
`ifndef DAC_CTRL_REGS_SVH
`define DAC_CTRL_REGS_SVH

// serial word layout
`define WORD_BITS 24
`define CNT_W 5
`define WORD_COUNT 5'd24
`define DATA_BITS 16
`define DATA_MSB 15
`define CH_LSB 16
`define CH_MSB 17
`define CH_BITS 2
`define NUM_CH 4
`define LOAD_FLAG 24
`define FIFO_WIDTH 25
`define FIFO_DEPTH 8

// clear codes
`define ZERO_SCALE 16'h0000
`define MID_SCALE 16'h8000

// host shift clock ceiling, and the core clock that samples it
`define SCLK_MAX_MHZ 30
`define SYS_CLK_MHZ 125

// positions in the pin sampling vector
`define PIN_W 8
`define PIN_SCLK 0
`define PIN_FRAME 1
`define PIN_DIN 2
`define PIN_LOAD 3
`define PIN_CLEAR 4
`define PIN_CODING 5
`define PIN_BIPOLAR 6
`define PIN_MID 7
// idle pin levels: shift clock, frame and clear all rest high
`define PIN_IDLE 8'h13

`endif

// File: hdl/quad_dac_serial_load_control.sv
`timescale 1ns/100ps

`include "dac_ctrl_regs.svh"

module word_fifo
#(
	parameter int WIDTH = `FIFO_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] fill;
	} fifo_state_type;

	fifo_state_type f_r;
	fifo_state_type f_nxt;
	logic do_wr;
	logic do_rd;

	assign in_ready = f_r.fill != (AW + 1)'(DEPTH);
	assign out_valid = f_r.fill != '0;
	assign out_data = f_r.mem[f_r.rd_ptr];
	assign do_wr = in_valid & in_ready;
	assign do_rd = out_valid & out_ready;

	always_comb
	begin
		f_nxt = f_r;
		if (do_wr)
		begin
			f_nxt.mem[f_r.wr_ptr] = in_data;
			f_nxt.wr_ptr = (f_r.wr_ptr == AW'(DEPTH - 1)) ? '0 : f_r.wr_ptr + 1'b1;
		end
		if (do_rd)
			f_nxt.rd_ptr = (f_r.rd_ptr == AW'(DEPTH - 1)) ? '0 : f_r.rd_ptr + 1'b1;
		if (do_wr && !do_rd)
			f_nxt.fill = f_r.fill + 1'b1;
		else if (do_rd && !do_wr)
			f_nxt.fill = f_r.fill - 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			f_r <= '0;
		else
			f_r <= f_nxt;
	end
endmodule

module quad_dac_serial_load_control
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic frame_sync_n,
	input wire logic shift_clk,
	input wire logic serial_data_in,
	input wire logic load_outputs_n,
	input wire logic async_clear_n,
	input wire logic coding_select,
	input wire logic bipolar_range,
	input wire logic clear_midscale,
	output logic serial_data_out,
	output logic buffer_ready,
	output logic word_dropped,
	output dac_ctrl_pkg::bank_type input_code,
	output dac_ctrl_pkg::bank_type dac_code
);
	import dac_ctrl_pkg::*;

	// offset binary and twos complement differ only in the top bit
	function automatic code_type to_straight(
		input code_type code,
		input logic bipolar,
		input logic coding
	);
		to_straight = code;
		if (bipolar && !coding)
			to_straight[`DATA_MSB] = ~code[`DATA_MSB];
	endfunction

	state_type s_r;
	state_type s_nxt;

	// pin samples leave reset at their idle levels, so no false edge or frame follows
	localparam state_type reset_state = '{
		meta: `PIN_IDLE,
		pins: `PIN_IDLE,
		sclk_prev: 1'b1,
		link: LINK_IDLE,
		default: '0
	};

	logic sclk;
	logic frame_n;
	logic sclk_fall;
	logic sclk_rise;
	logic load_fall;
	logic clear_on;
	code_type clear_code;
	logic pop_valid;
	logic pop;
	entry_type pop_data;
	logic [`CH_BITS-1:0] pop_ch;
	code_type pop_code;

	assign sclk = s_r.pins[`PIN_SCLK];
	assign frame_n = s_r.pins[`PIN_FRAME];
	// edges come from the second stage only; the host clock is a plain input
	assign sclk_fall = s_r.sclk_prev & ~sclk;
	assign sclk_rise = ~s_r.sclk_prev & sclk;
	assign load_fall = s_r.load_prev & ~s_r.pins[`PIN_LOAD];
	assign clear_on = ~s_r.pins[`PIN_CLEAR];
	assign clear_code = s_r.pins[`PIN_MID] ? `MID_SCALE : `ZERO_SCALE;
	assign pop_ch = pop_data[`CH_MSB:`CH_LSB];
	assign pop_code = to_straight(pop_data[`DATA_MSB:0], s_r.pins[`PIN_BIPOLAR],
		s_r.pins[`PIN_CODING]);
	// draining stalls while clear is held, so words queue behind it
	assign pop = pop_valid & ~clear_on;

	word_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(s_r.push),
		.in_ready(buffer_ready),
		.in_data(s_r.push_word),
		.out_valid(pop_valid),
		.out_ready(~clear_on),
		.out_data(pop_data)
	);

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.meta = {clear_midscale, bipolar_range, coding_select, async_clear_n,
			load_outputs_n, serial_data_in, frame_sync_n, shift_clk};
		s_nxt.pins = s_r.meta;
		s_nxt.sclk_prev = sclk;
		s_nxt.load_prev = s_r.pins[`PIN_LOAD];
		s_nxt.push = 1'b0;
		s_nxt.dropped = s_r.push & ~buffer_ready;
		if (sclk_rise)
			s_nxt.out_bit = s_r.shift[`WORD_BITS-1];
		case (s_r.link)
			LINK_IDLE:
			begin
				if (!frame_n)
				begin
					s_nxt.link = LINK_SHIFT;
					s_nxt.count = '0;
				end
			end
			LINK_SHIFT:
			begin
				if (frame_n)
				begin
					s_nxt.link = LINK_IDLE;
					// short frames are discarded; long ones keep the last word
					s_nxt.push = s_r.count == `WORD_COUNT;
					s_nxt.push_word = {~s_r.pins[`PIN_LOAD], s_r.shift};
				end
			end
			default:
				s_nxt.link = LINK_IDLE;
		endcase
		if (!frame_n && sclk_fall)
		begin
			s_nxt.shift = {s_r.shift[`WORD_BITS-2:0], s_r.pins[`PIN_DIN]};
			if (s_r.link == LINK_IDLE)
				s_nxt.count = `CNT_W'(1);
			else if (s_r.count != `WORD_COUNT)
				s_nxt.count = s_r.count + 1'b1;
		end
		if (pop)
		begin
			s_nxt.input_code[pop_ch] = pop_code;
			if (pop_data[`LOAD_FLAG])
				s_nxt.dac_code[pop_ch] = pop_code;
		end
		if (load_fall)
			s_nxt.dac_code = s_nxt.input_code;
		if (clear_on)
		begin
			for (int i = 0; i < `NUM_CH; i++)
				s_nxt.dac_code[i] = clear_code;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			s_r <= reset_state;
		else
			s_r <= s_nxt;
	end

	assign serial_data_out = s_r.out_bit;
	assign word_dropped = s_r.dropped;
	assign input_code = s_r.input_code;
	assign dac_code = s_r.dac_code;

	a_shift_on_fall: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(!frame_n && sclk_fall) |=> s_r.shift[0] == $past(s_r.pins[`PIN_DIN])
	) else $error("bit not captured on shift clock fall");

	a_hold_frame_high: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(frame_n && s_r.link == LINK_IDLE) |=> $stable(s_r.shift)
	) else $error("shift register moved outside a frame");

	a_latch_full_word: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(s_r.link == LINK_SHIFT && frame_n && s_r.count == `WORD_COUNT)
		|=> s_r.push && s_r.push_word[`WORD_BITS-1:0] == $past(s_r.shift)
	) else $error("word not latched at frame end");

	a_short_frame: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(s_r.link == LINK_SHIFT && frame_n && s_r.count != `WORD_COUNT) |=> !s_r.push
	) else $error("incomplete word was latched");

	a_out_on_rise: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		sclk_rise |=> serial_data_out == $past(s_r.shift[`WORD_BITS-1])
	) else $error("serial output not updated on rise");

	a_direct_update: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(pop && pop_data[`LOAD_FLAG])
		|=> dac_code[$past(pop_ch)] == $past(pop_code) || $past(load_fall)
	) else $error("addressed channel not updated");

	a_deferred_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(pop && !pop_data[`LOAD_FLAG] && !load_fall)
		|=> $stable(dac_code) && input_code[$past(pop_ch)] == $past(pop_code)
	) else $error("deferred write changed an output");

	a_load_all: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(load_fall && !clear_on) |=> dac_code == input_code
	) else $error("load fall did not update all channels");

	a_clear_codes: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clear_on |=> dac_code[0] == $past(clear_code)
			&& dac_code[`NUM_CH-1] == $past(clear_code)
	) else $error("clear did not force the clear code");

	a_unipolar_code: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!s_r.pins[`PIN_BIPOLAR] |-> pop_code == pop_data[`DATA_MSB:0]
	) else $error("unipolar code altered");

	a_twos_code: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(s_r.pins[`PIN_BIPOLAR] && !s_r.pins[`PIN_CODING])
		|-> pop_code[`DATA_MSB] != pop_data[`DATA_MSB]
	) else $error("twos complement top bit not flipped");

	a_rise_no_shift: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(!frame_n && sclk_rise) |=> $stable(s_r.shift)
	) else $error("shift register moved on a rising clock");

	a_out_only_rise: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!sclk_rise |=> $stable(serial_data_out)
	) else $error("serial output moved without a rising clock");

	a_frame_count_zero: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(s_r.link == LINK_IDLE && !frame_n && !sclk_fall) |=> s_r.count == '0
	) else $error("bit count not cleared at frame start");

	a_load_flag: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(s_r.link == LINK_SHIFT && frame_n)
		|=> s_r.push_word[`LOAD_FLAG] != $past(s_r.pins[`PIN_LOAD])
	) else $error("word update mode not taken from load level");

	a_dac_hold_idle: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(!pop && !load_fall && !clear_on) |=> $stable(dac_code)
	) else $error("output code moved without an update");

	a_input_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!pop |=> $stable(input_code)
	) else $error("input code moved without a word");
endmodule

// File: verification/host_serial_port.sv
`timescale 1ns/100ps
module host_serial_port
(
	output logic frame_sync_n,
	output logic shift_clk,
	output logic serial_data_in,
	input wire logic serial_data_out
);
	logic [47:0] rx;
	initial
	begin
		frame_sync_n = 1'b1;
		shift_clk = 1'b1;
		serial_data_in = 1'b0;
		rx = '0;
	end
	// clock rests high outside frames, so every edge in a frame starts with a fall
	task automatic send(input logic [47:0] w, input int n);
		frame_sync_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_data_in = w[i];
			#62.5 shift_clk = 1'b0;
			rx = {rx[46:0], serial_data_out};
			#62.5 shift_clk = 1'b1;
		end
		#62.5 frame_sync_n = 1'b1;
		// released data line must not keep showing the last bit
		serial_data_in = ~serial_data_in;
		#100;
	endtask
endmodule

// File: verification/test_quad_dac_serial_load_control.sv
`timescale 1ns/100ps
module test_quad_dac_serial_load_control;
	import dac_ctrl_pkg::*;
	logic sys_clk, rst_n, load_outputs_n, async_clear_n, coding_select;
	logic bipolar_range, clear_midscale, frame_sync_n, shift_clk, serial_data_in;
	logic serial_data_out, buffer_ready, word_dropped;
	bank_type input_code, dac_code;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	int drops = 0;

	quad_dac_serial_load_control uut
	(
		.sys_clk, .rst_n, .frame_sync_n, .shift_clk, .serial_data_in,
		.load_outputs_n, .async_clear_n, .coding_select, .bipolar_range,
		.clear_midscale, .serial_data_out, .buffer_ready, .word_dropped,
		.input_code, .dac_code
	);
	host_serial_port host
	(
		.frame_sync_n, .shift_clk, .serial_data_in, .serial_data_out
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// a hang costs one mismatch and goes straight to the verdict
	always @(posedge sys_clk)
	begin
		cycles++;
		if (word_dropped === 1'b1)
			drops++;
		if (cycles == 20000)
		begin
			bad_count++;
			$display("ERROR %0t timeout", $time);
			summarize();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t code %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [1:0] ch, input logic [15:0] code);
		host.send({30'h0, ch, code}, 24);
	endtask

	task automatic t_imm();
		load_outputs_n = 1'b0;
		for (int c = 0; c < 4; c++)
			wr(c[1:0], 16'ha5c0 + c[15:0]);
		tick(10);
		for (int c = 0; c < 4; c++)
		begin
			chk(input_code[c], 16'ha5c0 + c[15:0]);
			chk(dac_code[c], 16'ha5c0 + c[15:0]);
		end
	endtask

	task automatic t_defer();
		load_outputs_n = 1'b1;
		wr(2'd1, 16'h1234);
		tick(10);
		chk(input_code[1], 16'h1234);
		chk(dac_code[1], 16'ha5c1);
		load_outputs_n = 1'b0;
		tick(8);
		chk(dac_code[1], 16'h1234);
		chk(dac_code[0], 16'ha5c0);
	endtask

	task automatic t_code(input logic b, input logic c, input logic [15:0] v, input logic [15:0] e);
		bipolar_range = b;
		coding_select = c;
		wr(2'd2, v);
		tick(10);
		chk(dac_code[2], e);
	endtask

	task automatic t_clear();
		for (int m = 1; m >= 0; m--)
		begin
			clear_midscale = m[0];
			async_clear_n = 1'b0;
			tick(6);
			for (int c = 0; c < 4; c++)
				chk(dac_code[c], m ? 16'h8000 : 16'h0000);
			async_clear_n = 1'b1;
			tick(2);
		end
	endtask

	// clear stalls the drain, so the buffer fills and refuses the ninth word
	task automatic t_fifo();
		load_outputs_n = 1'b1;
		async_clear_n = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			if (i == 8)
				chk1(buffer_ready, 1'b0);
			wr(i[1:0], 16'h0100 + i[15:0]);
		end
		tick(4);
		chk1(drops == 1, 1'b1);
		async_clear_n = 1'b1;
		tick(30);
		chk1(buffer_ready, 1'b1);
		for (int c = 0; c < 4; c++)
			chk(input_code[c], 16'h0104 + c[15:0]);
		chk(dac_code[3], 16'h0000);
	endtask

	task automatic t_frames();
		load_outputs_n = 1'b0;
		host.send({24'h0, 8'h00, 16'h4444}, 23);
		tick(10);
		chk(input_code[0], 16'h0104);
		host.send({8'h03, 16'hbeef, 8'h01, 16'h5a5a}, 48);
		tick(10);
		chk(dac_code[1], 16'h5a5a);
		chk(host.rx[15:0], 16'hbeef);
	endtask

	initial
	begin
		rst_n = 1'b0;
		load_outputs_n = 1'b0;
		async_clear_n = 1'b1;
		coding_select = 1'b1;
		bipolar_range = 1'b0;
		clear_midscale = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(5);
		t_imm();
		t_defer();
		t_code(1'b1, 1'b0, 16'h0001, 16'h8001);
		t_code(1'b1, 1'b1, 16'h0001, 16'h0001);
		t_code(1'b0, 1'b0, 16'h7fff, 16'h7fff);
		t_clear();
		t_fifo();
		t_frames();
		summarize();
	end
endmodule
